// *** common/aid_map.svh ***
/*
 Opcode patterns, field codes and clock counts of the arithmetic
 instruction decoder.
 Assumes inclusion by bare name from the design files.
*/
`ifndef AID_MAP_SVH
`define AID_MAP_SVH

// ----------------------------------------
// override prefixes
// ----------------------------------------
`define AID_PFX_CODE 8'h2E
`define AID_PFX_STACK 8'h36
`define AID_PFX_DATA 8'h3E
`define AID_PFX_EXTRA 8'h26

// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define AID_TOP_ALU 2'h0
`define AID_GRP_IMM 6'h20
`define AID_GRP_F6 7'h7B
`define AID_GRP_FE 7'h7F
`define AID_REG_PLUS 5'h08
`define AID_REG_MINUS 5'h09
`define AID_ACC_TAIL 2'h2
`define AID_OP_ASCII_SUM 8'h37
`define AID_OP_ASCII_DIFF 8'h3F
`define AID_OP_BCD_SUM 8'h27
`define AID_OP_BCD_DIFF 8'h2F

// ----------------------------------------
// operation selector / extension codes
// ----------------------------------------
`define AID_SEL_SUM 3'h0
`define AID_SEL_SUM_C 3'h2
`define AID_SEL_DIFF_B 3'h3
`define AID_SEL_DIFF 3'h5
`define AID_SEL_COMPARE 3'h7
`define AID_EXT_PLUS 3'h0
`define AID_EXT_MINUS 3'h1
`define AID_EXT_SIGN 3'h3
`define AID_EXT_PRODUCT 3'h4

// ----------------------------------------
// addressing byte fields
// ----------------------------------------
`define AID_MOD_NODISP 2'h0
`define AID_MOD_DISP8 2'h1
`define AID_MOD_DISP16 2'h2
`define AID_MOD_REG 2'h3
`define AID_RM_DIRECT 3'h6

// ----------------------------------------
// clock counts
// ----------------------------------------
`define AID_CLK_PFX 8'h02
`define AID_CLK_RM_REG 8'h03
`define AID_CLK_RM_MEM 8'h0A
`define AID_CLK_IMM_REG 8'h04
`define AID_CLK_IMM_MEM 8'h10
`define AID_CLK_ACC_B 8'h03
`define AID_CLK_ACC_W 8'h04
`define AID_CLK_STEP_MEM 8'h0F
`define AID_CLK_ASCII_SUM 8'h08
`define AID_CLK_ASCII_DIFF 8'h07
`define AID_CLK_BCD 8'h04
`define AID_CLK_PR_RB_MIN 8'h1A
`define AID_CLK_PR_RB_MAX 8'h1C
`define AID_CLK_PR_RW_MIN 8'h23
`define AID_CLK_PR_RW_MAX 8'h25
`define AID_CLK_PR_MB_MIN 8'h20
`define AID_CLK_PR_MB_MAX 8'h22
`define AID_CLK_PR_MW_MIN 8'h29
`define AID_CLK_PR_MW_MAX 8'h2B
`define AID_CLK_XFER 8'h04

`endif

// *** common/aid_pkg.sv ***
/*
 Types of the arithmetic instruction decoder.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package aid_pkg;

   typedef enum logic [3:0] {
      AID_OP_NONE, AID_OP_SUM, AID_OP_SUM_C, AID_OP_DIFF,
      AID_OP_DIFF_B, AID_OP_COMPARE, AID_OP_PLUS1, AID_OP_MINUS1,
      AID_OP_SIGN, AID_OP_PRODUCT, AID_OP_ASCII_SUM,
      AID_OP_ASCII_DIFF, AID_OP_BCD_SUM, AID_OP_BCD_DIFF,
      AID_OP_PREFIX
   } aid_op_t;

   typedef enum logic [2:0] {
      AID_FM_NONE, AID_FM_RM, AID_FM_IMM, AID_FM_ACC,
      AID_FM_REG1, AID_FM_UNARY, AID_FM_PFX
   } aid_form_t;

   typedef enum logic [2:0] {
      AID_SEG_NONE, AID_SEG_EXTRA, AID_SEG_CODE,
      AID_SEG_STACK, AID_SEG_DATA
   } aid_seg_t;

   typedef enum logic {
      AID_ST_OPCODE = 1'b0,
      AID_ST_ADDR = 1'b1
   } aid_state_t;

   typedef struct packed {
      aid_op_t op;
      aid_form_t form;
      logic unsupported;
      logic wide;
      logic to_reg;
      logic mem;
      logic [1:0] mode;
      logic [2:0] reg_slot;
      logic [2:0] rm;
      aid_seg_t seg;
      logic [1:0] disp_bytes;
      logic [1:0] imm_bytes;
      logic [7:0] clk_min;
      logic [7:0] clk_max;
   } aid_result_t;

endpackage

// *** hdl/aid_decode.sv ***
/*
 Arithmetic instruction decoder: opcode and addressing byte in,
 one decoded record with execution clocks out.
 Assumes the fetch stream strips displacement and immediate bytes
 using the counts given in the record.
*/
//
// Contract
// - four prefixes select code, stack, data, extra segment; 2 clocks
// - sum: rm 3/10, immediate ext 000 4/16, accumulator 3/4
// - sum with carry: rm, immediate ext 010, accumulator; same times
// - difference: rm 3/10, immediate ext 101 4/16, accumulator 3/4
// - difference with borrow: rm, immediate ext 011, accumulator
// - sign change: 1111011w ext 011, 3 register, 10 memory
// - ascii sum fixup 8 clocks, ascii difference fixup 7 clocks
// - bcd sum and difference fixups take 4 clocks each
// - unsigned product ext 100, clocks by register/memory and width
// - word memory operands other than the product add 4 clocks per memory transfer
// - mode 11 names register; 00, 01, 10 memory; 01, 10 and direct 00 carry displacement
// - slot codes name word registers when wide, else byte registers
// - address computation time is inside listed memory times
`timescale 1ns/10ps
`include "aid_map.svh"

module aid_decode
   import aid_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // fetch stream
   input wire logic FETCH_VALID,
   input wire logic [7:0] FETCH_BYTE,
   output logic FETCH_READY,
   // decoded record
   output logic OUT_VALID,
   output aid_result_t OUT_RESULT
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   aid_state_t state;
   aid_state_t next_state;
   logic [7:0] held_op;
   aid_seg_t pend_seg;
   aid_seg_t next_seg;
   aid_result_t res;

   // ----------------------------------------
   // byte selection
   // ----------------------------------------
   wire take = FETCH_VALID;
   wire in_addr = (state == AID_ST_ADDR);
   wire [7:0] opc = in_addr ? held_op : FETCH_BYTE;
   wire [1:0] modf = FETCH_BYTE[7:6];
   wire [2:0] ext = FETCH_BYTE[5:3];
   wire [2:0] rmf = FETCH_BYTE[2:0];
   wire wide = opc[0];

   // ----------------------------------------
   // opcode classes
   // ----------------------------------------
   wire [2:0] alu_sel = opc[5:3];
   wire alu_top = (opc[7:6] == `AID_TOP_ALU);
   wire is_pfx = (opc == `AID_PFX_CODE) || (opc == `AID_PFX_STACK) ||
      (opc == `AID_PFX_DATA) || (opc == `AID_PFX_EXTRA);
   wire is_rm = alu_top && !opc[2] && alu_ok(alu_sel);
   wire is_acc = alu_top && (opc[2:1] == `AID_ACC_TAIL) &&
      alu_ok(alu_sel);
   wire is_grp = (opc[7:2] == `AID_GRP_IMM);
   wire is_f6 = (opc[7:1] == `AID_GRP_F6);
   wire is_fe = (opc[7:1] == `AID_GRP_FE);
   wire is_plus_r = (opc[7:3] == `AID_REG_PLUS);
   wire is_minus_r = (opc[7:3] == `AID_REG_MINUS);
   wire is_fix = (opc == `AID_OP_ASCII_SUM) ||
      (opc == `AID_OP_ASCII_DIFF) || (opc == `AID_OP_BCD_SUM) ||
      (opc == `AID_OP_BCD_DIFF);
   wire needs_modrm = is_rm || is_grp || is_f6 || is_fe;
   wire is_mem = (modf != `AID_MOD_REG);

   // ----------------------------------------
   // selector check and mapping
   // ----------------------------------------
   function automatic logic alu_ok(input logic [2:0] s);
      alu_ok = (s == `AID_SEL_SUM) || (s == `AID_SEL_SUM_C) ||
         (s == `AID_SEL_DIFF) || (s == `AID_SEL_DIFF_B) ||
         (s == `AID_SEL_COMPARE);
   endfunction

   function automatic aid_op_t alu_op(input logic [2:0] s);
      unique case (s)
         `AID_SEL_SUM: alu_op = AID_OP_SUM;
         `AID_SEL_SUM_C: alu_op = AID_OP_SUM_C;
         `AID_SEL_DIFF: alu_op = AID_OP_DIFF;
         `AID_SEL_DIFF_B: alu_op = AID_OP_DIFF_B;
         `AID_SEL_COMPARE: alu_op = AID_OP_COMPARE;
         default: alu_op = AID_OP_NONE;
      endcase
   endfunction

   // ----------------------------------------
   // displacement and immediate lengths
   // ----------------------------------------
   wire direct = (modf == `AID_MOD_NODISP) &&
      (rmf == `AID_RM_DIRECT);
   wire [1:0] disp_len = (modf == `AID_MOD_DISP8) ? 2'h1 :
      ((modf == `AID_MOD_DISP16) || direct) ? 2'h2 : 2'h0;
   wire [1:0] grp_imm = (opc[1:0] == 2'h1) ? 2'h2 : 2'h1;
   wire [1:0] acc_imm = wide ? 2'h2 : 2'h1;

   // ----------------------------------------
   // segment override tracking
   // ----------------------------------------
   function automatic aid_seg_t pfx_seg(input logic [7:0] b);
      unique case (b)
         `AID_PFX_CODE: pfx_seg = AID_SEG_CODE;
         `AID_PFX_STACK: pfx_seg = AID_SEG_STACK;
         `AID_PFX_DATA: pfx_seg = AID_SEG_DATA;
         `AID_PFX_EXTRA: pfx_seg = AID_SEG_EXTRA;
         default: pfx_seg = AID_SEG_NONE;
      endcase
   endfunction

   // ----------------------------------------
   // record assembly
   // ----------------------------------------
   logic writes_mem;

   always_comb
   begin
      res = '0;
      res.op = AID_OP_NONE;
      res.form = AID_FM_NONE;
      res.seg = pend_seg;
      res.wide = wide;
      writes_mem = 1'b1;
      if (in_addr)
      begin
         res.mode = modf;
         res.reg_slot = ext;
         res.rm = rmf;
         res.mem = is_mem;
         res.disp_bytes = disp_len;
      end
      if (is_pfx && !in_addr)
      begin
         res.op = AID_OP_PREFIX;
         res.form = AID_FM_PFX;
         res.seg = pfx_seg(opc);
         res.clk_min = `AID_CLK_PFX;
         res.clk_max = `AID_CLK_PFX;
      end
      else if (is_rm)
      begin
         res.op = alu_op(alu_sel);
         res.form = AID_FM_RM;
         res.to_reg = opc[1];
         writes_mem = !opc[1] && (res.op != AID_OP_COMPARE);
         res.clk_min = is_mem ? `AID_CLK_RM_MEM :
            `AID_CLK_RM_REG;
      end
      else if (is_grp)
      begin
         res.op = alu_op(ext);
         res.form = AID_FM_IMM;
         res.unsupported = !alu_ok(ext);
         res.imm_bytes = grp_imm;
         writes_mem = (res.op != AID_OP_COMPARE);
         if (res.op == AID_OP_COMPARE)
            res.clk_min = is_mem ? `AID_CLK_RM_MEM :
               `AID_CLK_RM_REG;
         else
            res.clk_min = is_mem ? `AID_CLK_IMM_MEM :
               `AID_CLK_IMM_REG;
      end
      else if (is_acc)
      begin
         res.op = alu_op(alu_sel);
         res.form = AID_FM_ACC;
         res.to_reg = 1'b1;
         res.imm_bytes = acc_imm;
         res.clk_min = wide ? `AID_CLK_ACC_W : `AID_CLK_ACC_B;
      end
      else if (is_fe)
      begin
         res.form = AID_FM_UNARY;
         res.unsupported = (ext != `AID_EXT_PLUS) &&
            (ext != `AID_EXT_MINUS);
         res.op = (ext == `AID_EXT_PLUS) ? AID_OP_PLUS1 :
            (ext == `AID_EXT_MINUS) ? AID_OP_MINUS1 : AID_OP_NONE;
         res.clk_min = is_mem ? `AID_CLK_STEP_MEM :
            `AID_CLK_RM_REG;
      end
      else if (is_f6)
      begin
         res.form = AID_FM_UNARY;
         if (ext == `AID_EXT_SIGN)
         begin
            res.op = AID_OP_SIGN;
            res.clk_min = is_mem ? `AID_CLK_RM_MEM :
               `AID_CLK_RM_REG;
         end
         else if (ext == `AID_EXT_PRODUCT)
         begin
            res.op = AID_OP_PRODUCT;
            res.to_reg = 1'b1;
            writes_mem = 1'b0;
            unique case ({is_mem, wide})
               2'h0: res.clk_min = `AID_CLK_PR_RB_MIN;
               2'h1: res.clk_min = `AID_CLK_PR_RW_MIN;
               2'h2: res.clk_min = `AID_CLK_PR_MB_MIN;
               2'h3: res.clk_min = `AID_CLK_PR_MW_MIN;
            endcase
            unique case ({is_mem, wide})
               2'h0: res.clk_max = `AID_CLK_PR_RB_MAX;
               2'h1: res.clk_max = `AID_CLK_PR_RW_MAX;
               2'h2: res.clk_max = `AID_CLK_PR_MB_MAX;
               2'h3: res.clk_max = `AID_CLK_PR_MW_MAX;
            endcase
         end
         else
            res.unsupported = 1'b1;
      end
      else if (is_plus_r || is_minus_r)
      begin
         res.op = is_plus_r ? AID_OP_PLUS1 : AID_OP_MINUS1;
         res.form = AID_FM_REG1;
         res.wide = 1'b1;
         res.to_reg = 1'b1;
         res.mode = `AID_MOD_REG;
         res.rm = opc[2:0];
         res.clk_min = `AID_CLK_RM_REG;
      end
      else if (is_fix)
      begin
         res.wide = 1'b0;
         res.form = AID_FM_REG1;
         res.to_reg = 1'b1;
         unique case (opc)
            `AID_OP_ASCII_SUM:
            begin
               res.op = AID_OP_ASCII_SUM;
               res.clk_min = `AID_CLK_ASCII_SUM;
            end
            `AID_OP_ASCII_DIFF:
            begin
               res.op = AID_OP_ASCII_DIFF;
               res.clk_min = `AID_CLK_ASCII_DIFF;
            end
            `AID_OP_BCD_SUM:
            begin
               res.op = AID_OP_BCD_SUM;
               res.clk_min = `AID_CLK_BCD;
            end
            default:
            begin
               res.op = AID_OP_BCD_DIFF;
               res.clk_min = `AID_CLK_BCD;
            end
         endcase
      end
      else
         res.unsupported = 1'b1;
      if (res.unsupported)
         res.clk_min = '0;
      if (res.op != AID_OP_PRODUCT)
         res.clk_max = res.clk_min;
      // word memory operand: one or two transfers
      if (res.mem && res.wide && res.op != AID_OP_PRODUCT &&
         !res.unsupported)
      begin
         res.clk_min = res.clk_min + (writes_mem ?
            (`AID_CLK_XFER << 1) : `AID_CLK_XFER);
         res.clk_max = res.clk_min;
      end
   end

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   wire emit = take && (in_addr || !needs_modrm);
   wire to_addr = take && !in_addr && needs_modrm;

   assign FETCH_READY = 1'b1;
   assign next_state = to_addr ? AID_ST_ADDR :
      (take ? AID_ST_OPCODE : state);
   assign next_seg = (emit && is_pfx && !in_addr) ? pfx_seg(opc) :
      (emit ? AID_SEG_NONE : pend_seg);

   always_ff @(posedge REF_CLK)
   begin
      if (!RESETN)
      begin
         state <= AID_ST_OPCODE;
         held_op <= 8'h00;
         pend_seg <= AID_SEG_NONE;
         OUT_VALID <= 1'b0;
         OUT_RESULT <= '0;
      end
      else
      begin
         state <= next_state;
         pend_seg <= next_seg;
         OUT_VALID <= emit;
         if (to_addr)
            held_op <= FETCH_BYTE;
         if (emit)
            OUT_RESULT <= res;
      end
   end

endmodule // aid_decode

// *** verification/aid_decode_checker.sv ***
/*
 Port checker of the arithmetic instruction decoder.
 Assumes binding to aid_decode and the aid_pkg types.
*/
`timescale 1ns/10ps

module aid_decode_checker
   import aid_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // fetch stream
   input wire logic FETCH_VALID,
   input wire logic [7:0] FETCH_BYTE,
   input wire logic FETCH_READY,
   // decoded record
   input wire logic OUT_VALID,
   input wire aid_result_t OUT_RESULT
);
   // ----------------------------------------
   // byte position tracking
   // ----------------------------------------
   logic in_addr;
   logic [7:0] opc;
   aid_seg_t pfx_seg;
   wire [7:0] b = FETCH_BYTE;
   wire alu = b[7:6] == 2'h0 && b[5:3] inside {3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
   wire need = (alu && !b[2]) || b[7:2] == 6'h20 || b[7:1] == 7'h7B
      || b[7:1] == 7'h7F;
   wire take = FETCH_VALID && FETCH_READY;
   wire t_op = take && !in_addr;
   wire t_ad = take && in_addr;
   wire is_pfx = b inside {8'h2E, 8'h36, 8'h3E, 8'h26};
   wire grp6 = opc[7:1] == 7'h7B;
   assign pfx_seg = b[4] ? (b[3] ? AID_SEG_DATA : AID_SEG_STACK)
      : (b[3] ? AID_SEG_CODE : AID_SEG_EXTRA);

   always_ff @(posedge REF_CLK)
   begin
      if (!RESETN)
         in_addr <= 1'b0;
      else if (take)
         in_addr <= !in_addr && need;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (t_op)
         opc <= b;
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);

   AST_PFX_TIME:
      assert property (t_op && is_pfx |=> OUT_VALID
         && OUT_RESULT.op == AID_OP_PREFIX && OUT_RESULT.clk_min == 8'h02)
      else $error("prefix record wrong");
   AST_PFX_SEG:
      assert property (t_op && is_pfx |=> OUT_RESULT.seg == $past(pfx_seg))
      else $error("prefix segment wrong");
   AST_ASCII:
      assert property (t_op && b inside {8'h37, 8'h3F} |=>
         OUT_RESULT.clk_min == ($past(b[3]) ? 8'h07 : 8'h08))
      else $error("ascii fixup clocks wrong");
   AST_BCD:
      assert property (t_op && b inside {8'h27, 8'h2F} |=>
         OUT_RESULT.clk_min == 8'h04 && OUT_RESULT.clk_max == 8'h04)
      else $error("bcd fixup clocks wrong");
   AST_ACC:
      assert property (t_op && alu && b[2:1] == 2'h2 |=> !OUT_RESULT.mem
         && OUT_RESULT.clk_min == ($past(b[0]) ? 8'h04 : 8'h03)
         && OUT_RESULT.imm_bytes == ($past(b[0]) ? 2'h2 : 2'h1))
      else $error("accumulator form clocks wrong");
   AST_DUE:
      assert property (take && (in_addr || !need) |=> OUT_VALID)
      else $error("record missing after final byte");
   AST_WAIT_ADDR:
      assert property (t_op && need |=> !OUT_VALID)
      else $error("record before addressing byte");
   AST_DISP:
      assert property (t_ad |=> OUT_RESULT.disp_bytes ==
         (($past(b[7:6]) == 2'h1) ? 2'h1 : (($past(b[7:6]) == 2'h2 ||
         ($past(b[7:6]) == 2'h0 && $past(b[2:0]) == 3'h6)) ? 2'h2 : 2'h0)))
      else $error("displacement length wrong");
   AST_RM_DIR:
      assert property (t_ad && opc[7:6] == 2'h0 && !opc[2] |=>
         OUT_RESULT.to_reg == $past(opc[1])
         && OUT_RESULT.wide == $past(opc[0]))
      else $error("direction or width wrong");
   AST_GRP_IMM:
      assert property (t_ad && opc[7:2] == 6'h20 |=> OUT_RESULT.imm_bytes ==
         ($past(opc[1:0]) == 2'h1 ? 2'h2 : 2'h1))
      else $error("immediate length wrong");
   AST_UNSUP:
      assert property (t_ad && ((grp6 && !(b[5:3] inside {3'h3, 3'h4})) ||
         (opc[7:1] == 7'h7F && b[5:4] != 2'h0) ||
         (opc[7:2] == 6'h20 && b[5:3] inside {3'h1, 3'h4, 3'h6})) |=>
         OUT_RESULT.unsupported && OUT_RESULT.op == AID_OP_NONE
         && OUT_RESULT.clk_min == 8'h00)
      else $error("refused encoding reported wrong");
   AST_FIELDS:
      assert property (t_ad |=> OUT_RESULT.mode == $past(b[7:6])
         && OUT_RESULT.reg_slot == $past(b[5:3])
         && OUT_RESULT.rm == $past(b[2:0]) && (OUT_RESULT.unsupported
         || OUT_RESULT.mem == ($past(b[7:6]) != 2'h3)))
      else $error("addressing fields wrong");
   AST_PRODUCT:
      assert property (t_ad && grp6 && b[5:3] == 3'h4 |=>
         OUT_RESULT.op == AID_OP_PRODUCT
         && OUT_RESULT.clk_max == OUT_RESULT.clk_min + 8'h02
         && OUT_RESULT.clk_min == ($past(opc[0]) ? 8'h23 : 8'h1A)
         + ($past(b[7:6]) == 2'h3 ? 8'h00 : 8'h06))
      else $error("product clocks wrong");
   AST_SIGN:
      assert property (t_ad && grp6 && b[5:3] == 3'h3 |=>
         OUT_RESULT.op == AID_OP_SIGN && OUT_RESULT.clk_min ==
         ($past(b[7:6]) == 2'h3 ? 8'h03 : ($past(opc[0]) ? 8'h12 : 8'h0A)))
      else $error("sign change clocks wrong");
   AST_STEP_REG:
      assert property (t_op && b[7:4] == 4'h4 |=> OUT_RESULT.clk_min == 8'h03
         && OUT_RESULT.op == ($past(b[3]) ? AID_OP_MINUS1 : AID_OP_PLUS1)
         && OUT_RESULT.rm == $past(b[2:0]) && OUT_RESULT.wide)
      else $error("register step wrong");
endmodule // aid_decode_checker

bind aid_decode aid_decode_checker chk (
   .REF_CLK(REF_CLK),
   .RESETN(RESETN),
   .FETCH_VALID(FETCH_VALID),
   .FETCH_BYTE(FETCH_BYTE),
   .FETCH_READY(FETCH_READY),
   .OUT_VALID(OUT_VALID),
   .OUT_RESULT(OUT_RESULT)
);

// *** verification/aid_fetch_src.sv ***
/*
 Fetch stream source: offers queued bytes, one per edge; with SLOW, none on every fourth edge.
 Assumes the bench queues only opcode and addressing bytes.
*/
`timescale 1ns/10ps

module aid_fetch_src
(
   // clock and pacing
   input wire logic REF_CLK,
   input wire logic SLOW,
   // fetch stream
   output logic FETCH_VALID,
   output logic [7:0] FETCH_BYTE,
   input wire logic FETCH_READY
);
   logic [7:0] fifo [$];
   logic [1:0] cnt = 2'h0;

   initial
   begin
      FETCH_VALID = 1'b0;
      FETCH_BYTE = 8'h00;
   end

   task automatic put(input logic [7:0] v);
      fifo.push_back(v);
   endtask

   // idle byte is scrambled so a stale value never looks valid
   always @(posedge REF_CLK)
   begin
      cnt <= cnt + 2'h1;
      if (!FETCH_VALID || FETCH_READY)
      begin
         if (fifo.size() > 0 && !(SLOW && cnt == 2'h3))
         begin
            FETCH_VALID <= 1'b1;
            FETCH_BYTE <= fifo.pop_front();
         end
         else
         begin
            FETCH_VALID <= 1'b0;
            FETCH_BYTE <= ~FETCH_BYTE;
         end
      end
   end
endmodule // aid_fetch_src

// *** verification/tb.sv ***
/*
 Self-checking bench of the arithmetic instruction decoder.
 Assumes aid_fetch_src as stream source and the bound checker.
*/
`timescale 1ns/10ps

module tb
   import aid_pkg::*;
;
   typedef struct packed {
      aid_op_t op;
      aid_seg_t seg;
      logic mem;
      logic [2:0] slot;
      logic [7:0] lo;
      logic [7:0] hi;
   } aid_exp_t;

   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic slow = 1'b0;
   logic fetch_valid, fetch_ready, out_valid;
   logic [7:0] fetch_byte;
   aid_result_t out_result;
   aid_exp_t exq [$];
   aid_exp_t e;
   aid_seg_t seg = AID_SEG_NONE;
   int failures = 0;
   int num_checks = 0;
   logic [31:0] rnd = 32'h2455;
   logic [31:0] r;
   int i;
   logic [2:0] sels [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
   aid_op_t ops [5] = '{AID_OP_SUM, AID_OP_SUM_C, AID_OP_DIFF_B,
      AID_OP_DIFF, AID_OP_COMPARE};

   always #2.5 ref_clk = ~ref_clk;

   aid_fetch_src src (.REF_CLK(ref_clk), .SLOW(slow),
      .FETCH_VALID(fetch_valid), .FETCH_BYTE(fetch_byte),
      .FETCH_READY(fetch_ready));
   aid_decode dut (.REF_CLK(ref_clk), .RESETN(resetn),
      .FETCH_VALID(fetch_valid), .FETCH_BYTE(fetch_byte),
      .FETCH_READY(fetch_ready), .OUT_VALID(out_valid),
      .OUT_RESULT(out_result));

   function automatic logic [31:0] xs();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd;
   endfunction

   task automatic chk(input string nm, input logic [7:0] x, y);
      num_checks++;
      if (x !== y)
      begin
         failures++;
         $display("Error %s expected %0h seen %0h", nm, x, y);
      end
   endtask

   task automatic test_done();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // queue bytes and note the record they must yield
   task automatic ins(input logic [7:0] b0, b1, input int n,
      input aid_op_t op, input logic [7:0] c);
      aid_exp_t x;
      src.put(b0);
      if (n > 1)
         src.put(b1);
      x.op = op;
      x.seg = seg;
      x.mem = n > 1 && b1[7:6] != 2'h3;
      x.slot = n > 1 ? b1[5:3] : 3'h0;
      x.lo = c;
      x.hi = op == AID_OP_PRODUCT ? c + 8'h02 : c;
      exq.push_back(x);
      seg = AID_SEG_NONE;
   endtask

   task automatic pfx(input logic [7:0] b, input aid_seg_t s);
      seg = s;
      ins(b, 8'h00, 1, AID_OP_PREFIX, 8'h02);
      seg = s;
   endtask

   task automatic drain(input string nm);
      for (int k = 0; k < 400 && exq.size() > 0; k++)
         @(posedge ref_clk);
      if (exq.size() > 0)
      begin
         failures++;
         $display("Error %s expected drained seen %0d", nm, exq.size());
         test_done();
      end
      else
         $display("test %s done", nm);
   endtask

   // ----------------------------------------
   // record monitor
   // ----------------------------------------
   always @(posedge ref_clk)
   begin
      if (out_valid === 1'b1)
      begin
         if (exq.size() == 0)
            chk("spare record", 8'h00, 8'h01);
         else
         begin
            e = exq.pop_front();
            chk("op", 8'(e.op), 8'(out_result.op));
            chk("seg", 8'(e.seg), 8'(out_result.seg));
            chk("mem", 8'(e.mem), 8'(out_result.mem));
            chk("slot", 8'(e.slot), 8'(out_result.reg_slot));
            chk("clk_min", e.lo, out_result.clk_min);
            chk("clk_max", e.hi, out_result.clk_max);
         end
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      pfx(8'h2E, AID_SEG_CODE);
      ins(8'h01, 8'hC1, 2, AID_OP_SUM, 8'h03);
      pfx(8'h36, AID_SEG_STACK);
      pfx(8'h3E, AID_SEG_DATA);
      ins(8'hF7, 8'h26, 2, AID_OP_PRODUCT, 8'h29);
      pfx(8'h26, AID_SEG_EXTRA);
      ins(8'h37, 8'h00, 1, AID_OP_ASCII_SUM, 8'h08);
      ins(8'h3F, 8'h00, 1, AID_OP_ASCII_DIFF, 8'h07);
      pfx(8'h3E, AID_SEG_DATA);
      drain("prefix");
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("reset valid", 8'(out_valid), 8'h00);
      chk("reset clocks", out_result.clk_min, 8'h00);
      resetn <= 1'b1;
      seg = AID_SEG_NONE;
      ins(8'h00, 8'h07, 2, AID_OP_SUM, 8'h0A);
      ins(8'h01, 8'h06, 2, AID_OP_SUM, 8'h12);
      ins(8'h80, 8'hC0, 2, AID_OP_SUM, 8'h04);
      ins(8'h81, 8'h07, 2, AID_OP_SUM, 8'h18);
      ins(8'h04, 8'h00, 1, AID_OP_SUM, 8'h03);
      ins(8'h05, 8'h00, 1, AID_OP_SUM, 8'h04);
      ins(8'h13, 8'hC0, 2, AID_OP_SUM_C, 8'h03);
      ins(8'h83, 8'hD0, 2, AID_OP_SUM_C, 8'h04);
      ins(8'h15, 8'h00, 1, AID_OP_SUM_C, 8'h04);
      ins(8'h2B, 8'h47, 2, AID_OP_DIFF, 8'h0E);
      ins(8'h81, 8'hE8, 2, AID_OP_DIFF, 8'h04);
      ins(8'h2C, 8'h00, 1, AID_OP_DIFF, 8'h03);
      ins(8'h18, 8'hC0, 2, AID_OP_DIFF_B, 8'h03);
      ins(8'h80, 8'hD8, 2, AID_OP_DIFF_B, 8'h04);
      ins(8'h1D, 8'h00, 1, AID_OP_DIFF_B, 8'h04);
      ins(8'hF6, 8'hD8, 2, AID_OP_SIGN, 8'h03);
      ins(8'hF7, 8'h1F, 2, AID_OP_SIGN, 8'h12);
      ins(8'h27, 8'h00, 1, AID_OP_BCD_SUM, 8'h04);
      ins(8'h2F, 8'h00, 1, AID_OP_BCD_DIFF, 8'h04);
      ins(8'hF6, 8'hE0, 2, AID_OP_PRODUCT, 8'h1A);
      ins(8'hF7, 8'hE0, 2, AID_OP_PRODUCT, 8'h23);
      ins(8'hF6, 8'h20, 2, AID_OP_PRODUCT, 8'h20);
      ins(8'hFE, 8'h00, 2, AID_OP_PLUS1, 8'h0F);
      ins(8'hFF, 8'h48, 2, AID_OP_MINUS1, 8'h17);
      ins(8'h40, 8'h00, 1, AID_OP_PLUS1, 8'h03);
      ins(8'h4F, 8'h00, 1, AID_OP_MINUS1, 8'h03);
      ins(8'h3B, 8'h07, 2, AID_OP_COMPARE, 8'h0E);
      ins(8'h38, 8'hC0, 2, AID_OP_COMPARE, 8'h03);
      ins(8'h83, 8'hF8, 2, AID_OP_COMPARE, 8'h03);
      ins(8'h3C, 8'h00, 1, AID_OP_COMPARE, 8'h03);
      ins(8'hF6, 8'hF0, 2, AID_OP_NONE, 8'h00);
      ins(8'hFE, 8'hD0, 2, AID_OP_NONE, 8'h00);
      ins(8'h80, 8'hC8, 2, AID_OP_NONE, 8'h00);
      ins(8'h02, 8'h88, 2, AID_OP_SUM, 8'h0A);
      drain("forms");
      slow <= 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         r = xs();
         i = r[15:0] % 5;
         ins({2'h0, sels[i], 1'b0, r[17:16]}, {2'h3, r[5:0]}, 2, ops[i],
            8'h03);
      end
      drain("random");
      test_done();
   end
endmodule // tb
